// ---- core/txm_pkg.sv ----
package txm_pkg;

  // Serial word layout
  localparam int unsigned WORD_W     = 20;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam logic [4:0]  WORD_CNT   = 5'h14;
  localparam logic [4:0]  CNT_MAX    = 5'h1F;
  localparam logic [4:0]  CNT_FIRST  = 5'h01;

  // Register addresses
  localparam logic [3:0]  ADDR_REF   = 4'h0;
  localparam logic [3:0]  ADDR_MAIN  = 4'h2;
  localparam logic [3:0]  ADDR_CTRL  = 4'h4;

  // Power-up contents
  localparam logic [15:0] RST_REF    = 16'h4050;
  localparam logic [15:0] RST_MAIN   = 16'h2616;
  localparam logic [15:0] RST_CTRL   = 16'h197D;

  // Operation control bit positions
  localparam int unsigned B_PWR      = 0;
  localparam int unsigned B_KEEP     = 1;
  localparam int unsigned B_FILT     = 3;
  localparam int unsigned B_PLL      = 4;
  localparam int unsigned B_OSC      = 5;
  localparam int unsigned B_TX       = 6;
  localparam int unsigned B_DBL      = 7;
  localparam int unsigned B_MPL      = 8;
  localparam int unsigned B_PRD      = 9;
  localparam int unsigned B_OUTB     = 10;
  localparam int unsigned B_PUMP_LO  = 11;
  localparam int unsigned B_TRIM_LO  = 13;
  localparam int unsigned B_TRIM_MD  = 15;

  // Reference divider field positions
  localparam int unsigned R_RATIO_HI = 8;
  localparam int unsigned R_LOCK_LO  = 9;
  localparam int unsigned R_TEST_LO  = 11;

  // Lock pin sources
  localparam logic [1:0]  LOCK_DET   = 2'h0;
  localparam logic [1:0]  LOCK_MAIN  = 2'h1;
  localparam logic [1:0]  LOCK_REF   = 2'h2;

  // Charge-pump test codes
  localparam logic [2:0]  PT_BOTH_ON = 3'h1;
  localparam logic [2:0]  PT_SNK_ON  = 3'h3;
  localparam logic [2:0]  PT_SRC_ON  = 3'h5;
  localparam logic [2:0]  PT_OFF     = 3'h6;

  // Synchronised pin indices
  localparam int unsigned PIN_N      = 6;
  localparam int unsigned P_CS       = 0;
  localparam int unsigned P_POWER_DOWN_CTL     = 1;
  localparam int unsigned P_STBY     = 2;
  localparam int unsigned P_LOCK     = 3;
  localparam int unsigned P_MDIV     = 4;
  localparam int unsigned P_RDIV     = 5;
  localparam logic [5:0]  PIN_RST    = 6'h01;

  typedef enum logic [2:0] {
    TXM_ACTIVE   = 3'h1,
    TXM_STANDBY  = 3'h2,
    TXM_SHUTDOWN = 3'h4
  } txm_mode_type;

endpackage : txm_pkg

// ---- core/txm_ctrl_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Address 0010 selects main divider, 0000 reference, 0100 control.
// - Reset loads main 9750, reference 0x4050, control 0x197D.
// - Control bit 0 low powers down all but serial port; registers kept.
// - Low shutdown pin forces full shutdown regardless of bit 0.
// - Bit 1 high keeps filters and servo on in standby; low turns off.
// - Bit 3 low bypasses baseband filters; high routes through them.
// - Bit 4 enables the PLL, bit 5 enables the oscillator.
// - Bit 6 low disables driver, upconverter and IF modulator together.
// - Bit 7 high enables the reference frequency doubler.
// - Bit 8 selects maximum output power, one high, zero low.
// - Bit 9 predriver bias, zero reduced; bit 10 output bias, one raised.
// - Bits 12:11 select charge-pump current, four steps.
// - Bits 14:13 select trim current, used only in trimming mode.
// - Bit 15 high enters DC offset trimming mode.
// - Reference bits 10:9 select the lock indicator pin source.
// - Reference bits 13:11 force charge-pump source and sink for test.
// - Serial words are 20 bits, MSB first, data then address.
// - Data is sampled on rising serial clock while chip select low.
// - Chip select rising edge after exactly 20 bits loads the addressed register.
// - In standby PLL and oscillator keep the bit 4 and bit 5 settings from before.
module txm_ctrl_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_serial_data_in,
  input  wire logic        i_shutdown_n,
  input  wire logic        i_standby_n,
  input  wire logic        i_lock_detect,
  input  wire logic        i_main_div_out,
  input  wire logic        i_ref_div_out,
  output logic             o_pll_on,
  output logic             o_oscillator_on,
  output logic             o_tx_chain_on,
  output logic             o_filter_power_on,
  output logic             o_baseband_filter_on,
  output logic             o_ref_doubler_on,
  output logic             o_max_power_sel,
  output logic             o_predriver_bias_sel,
  output logic             o_output_bias_sel,
  output logic [1:0]       o_pump_current_sel,
  output logic [1:0]       o_trim_current_sel,
  output logic             o_offset_trim_mode,
  output logic [8:0]       o_ref_divide_ratio,
  output logic [15:0]      o_main_divider,
  output logic             o_pump_src_force,
  output logic             o_pump_snk_force,
  output logic             o_pump_test_on,
  output logic             o_lock_indicator_pin
);

  default clocking sys_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  logic [19:0]            shift_q;
  logic [4:0]             cnt_q;
  logic                   armed_q;
  logic [5:0]             pin_s1_q;
  logic [5:0]             pin_s2_q;
  logic                   cs_s3_q;
  logic                   load;
  logic [3:0]             addr;
  logic [15:0]            data;
  logic [15:0]            ref_q;
  logic [15:0]            main_q;
  logic [15:0]            ctrl_q;
  logic                   full_power_down_ctl;
  txm_pkg::txm_mode_type  mode_q;
  txm_pkg::txm_mode_type  mode_d;
  logic                   pll_hold_q;
  logic                   osc_hold_q;
  logic [2:0]             ptest;

  // Link side: runs on serial clock edges, which stop between frames, and on chip-select rise
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b0;
    end
  end

  // Other receivers share the clock line, so chip select gates the shift
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n) begin
      shift_q <= {shift_q[18:0], i_serial_data_in};
    end
  end

  always_ff @(posedge i_sclk) begin
    if (!i_cs_n) begin
      if (armed_q) begin
        cnt_q <= txm_pkg::CNT_FIRST;
      end else if (cnt_q != txm_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + txm_pkg::CNT_FIRST;
      end
    end
  end

  AST_SHIFT_IN: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    1'b1 |=> shift_q[0] == $past(i_serial_data_in))
    else $error("serial bit not shifted in");

  AST_FIRST_BIT: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    armed_q |=> cnt_q == 5'h01 && !armed_q)
    else $error("frame bit count not restarted");

  // Pin synchronisers; the second stage is read, plus a third stage for chip select
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pin_s1_q <= txm_pkg::PIN_RST;
      pin_s2_q <= txm_pkg::PIN_RST;
      cs_s3_q  <= 1'b1;
    end else if (i_ce) begin
      pin_s1_q <= {i_ref_div_out, i_main_div_out, i_lock_detect,
                   i_standby_n, i_shutdown_n, i_cs_n};
      pin_s2_q <= pin_s1_q;
      cs_s3_q  <= pin_s2_q[txm_pkg::P_CS];
    end
  end

  // Shift word is quiet once chip select is high, so it is read directly
  assign load = pin_s2_q[txm_pkg::P_CS] & ~cs_s3_q
              & (cnt_q == txm_pkg::WORD_CNT);
  assign addr = shift_q[3:0];
  assign data = shift_q[19:4];

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ref_q  <= txm_pkg::RST_REF;
      main_q <= txm_pkg::RST_MAIN;
      ctrl_q <= txm_pkg::RST_CTRL;
    end else if (i_ce && load) begin
      case (addr)
        txm_pkg::ADDR_REF: begin
          ref_q <= data;
        end
        txm_pkg::ADDR_MAIN: begin
          main_q <= data;
        end
        txm_pkg::ADDR_CTRL: begin
          ctrl_q <= data;
        end
        default: begin
          ref_q <= ref_q;
        end
      endcase
    end
  end

  AST_RESET_DEFAULTS: assert property (
    $rose(i_resetn) |-> ref_q == 16'h4050 && main_q == 16'd9750
      && ctrl_q == 16'h197D)
    else $error("registers not at power-up values");

  AST_LOAD_MAIN: assert property (
    i_ce && load && addr == 4'h2 |=> main_q == $past(data))
    else $error("main divider not loaded");

  AST_LOAD_CTRL: assert property (
    i_ce && load && addr == 4'h4 |=> ctrl_q == $past(data)
      && $stable(ref_q) && $stable(main_q))
    else $error("control word not loaded alone");

  AST_BAD_ADDR: assert property (
    i_ce && load && addr != 4'h0 && addr != 4'h2 && addr != 4'h4
      |=> $stable(ref_q) && $stable(main_q) && $stable(ctrl_q))
    else $error("unknown address changed a register");

  // The pin wins over the software bit
  assign full_power_down_ctl = ~pin_s2_q[txm_pkg::P_POWER_DOWN_CTL]
                   | ~ctrl_q[txm_pkg::B_PWR];

  always_comb begin
    mode_d = txm_pkg::TXM_ACTIVE;
    if (full_power_down_ctl) begin
      mode_d = txm_pkg::TXM_SHUTDOWN;
    end else if (!pin_s2_q[txm_pkg::P_STBY]) begin
      mode_d = txm_pkg::TXM_STANDBY;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      mode_q     <= txm_pkg::TXM_SHUTDOWN;
      pll_hold_q <= 1'b0;
      osc_hold_q <= 1'b0;
    end else if (i_ce) begin
      mode_q <= mode_d;
      // Track until standby starts, so its first cycle shows the kept state
      if (mode_d != txm_pkg::TXM_STANDBY) begin
        pll_hold_q <= ctrl_q[txm_pkg::B_PLL];
        osc_hold_q <= ctrl_q[txm_pkg::B_OSC];
      end
    end
  end

  // Power enables; registers stay untouched in every mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_pll_on          <= 1'b0;
      o_oscillator_on   <= 1'b0;
      o_tx_chain_on     <= 1'b0;
      o_filter_power_on <= 1'b0;
      o_ref_doubler_on  <= 1'b0;
    end else if (i_ce) begin
      case (mode_d)
        txm_pkg::TXM_ACTIVE: begin
          o_pll_on          <= ctrl_q[txm_pkg::B_PLL];
          o_oscillator_on   <= ctrl_q[txm_pkg::B_OSC];
          o_tx_chain_on     <= ctrl_q[txm_pkg::B_TX];
          o_filter_power_on <= 1'b1;
          o_ref_doubler_on  <= ctrl_q[txm_pkg::B_DBL];
        end
        txm_pkg::TXM_STANDBY: begin
          o_pll_on          <= pll_hold_q;
          o_oscillator_on   <= osc_hold_q;
          o_tx_chain_on     <= 1'b0;
          o_filter_power_on <= ctrl_q[txm_pkg::B_KEEP];
          o_ref_doubler_on  <= ctrl_q[txm_pkg::B_DBL];
        end
        default: begin
          o_pll_on          <= 1'b0;
          o_oscillator_on   <= 1'b0;
          o_tx_chain_on     <= 1'b0;
          o_filter_power_on <= 1'b0;
          o_ref_doubler_on  <= 1'b0;
        end
      endcase
    end
  end

  AST_SOFT_POWER_DOWN_CTL: assert property (
    i_ce && !ctrl_q[0] |=> !o_pll_on && !o_oscillator_on
      && !o_tx_chain_on && !o_filter_power_on && !o_ref_doubler_on)
    else $error("function powered while shut down by bit");

  AST_PIN_POWER_DOWN_CTL: assert property (
    i_ce && !pin_s2_q[txm_pkg::P_POWER_DOWN_CTL] && ctrl_q[0]
      |=> !o_pll_on && !o_tx_chain_on && !o_oscillator_on)
    else $error("shutdown pin did not override bit");

  AST_STBY_FILTER: assert property (
    i_ce && mode_d == txm_pkg::TXM_STANDBY
      |=> o_filter_power_on == $past(ctrl_q[1]) && !o_tx_chain_on)
    else $error("standby filter power wrong");

  AST_STBY_HOLD: assert property (
    i_ce && mode_q == txm_pkg::TXM_STANDBY
      && mode_d == txm_pkg::TXM_STANDBY
      |=> o_pll_on == $past(pll_hold_q)
        && o_oscillator_on == $past(osc_hold_q))
    else $error("PLL or oscillator left held state in standby");

  AST_TX_CHAIN: assert property (
    i_ce && !ctrl_q[6] |=> !o_tx_chain_on)
    else $error("transmit chain on with bit 6 clear");

  // Selections and divide ratios
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_baseband_filter_on <= 1'b0;
      o_max_power_sel      <= 1'b0;
      o_predriver_bias_sel <= 1'b0;
      o_output_bias_sel    <= 1'b0;
      o_pump_current_sel   <= 2'h0;
      o_trim_current_sel   <= 2'h0;
      o_offset_trim_mode   <= 1'b0;
      o_ref_divide_ratio   <= 9'h000;
      o_main_divider       <= 16'h0000;
    end else if (i_ce) begin
      o_baseband_filter_on <= ctrl_q[txm_pkg::B_FILT];
      o_max_power_sel      <= ctrl_q[txm_pkg::B_MPL];
      o_predriver_bias_sel <= ctrl_q[txm_pkg::B_PRD];
      o_output_bias_sel    <= ctrl_q[txm_pkg::B_OUTB];
      o_pump_current_sel   <= ctrl_q[txm_pkg::B_PUMP_LO +: 2];
      o_offset_trim_mode   <= ctrl_q[txm_pkg::B_TRIM_MD];
      // Trim current only reaches the analog side in trimming mode
      o_trim_current_sel   <= ctrl_q[txm_pkg::B_TRIM_MD]
                              ? ctrl_q[txm_pkg::B_TRIM_LO +: 2]
                              : 2'h0;
      o_ref_divide_ratio   <= ref_q[txm_pkg::R_RATIO_HI:0];
      o_main_divider       <= main_q;
    end
  end

  AST_TRIM_GATE: assert property (
    i_ce && !ctrl_q[15] |=> o_trim_current_sel == 2'h0 && !o_offset_trim_mode)
    else $error("trim current outside trimming mode");

  AST_PUMP_CUR: assert property (
    i_ce |=> o_pump_current_sel == $past(ctrl_q[12:11]))
    else $error("pump current select mismatch");

  // Charge-pump test forcing; codes not listed act as normal
  assign ptest = ref_q[txm_pkg::R_TEST_LO +: 3];

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_pump_src_force <= 1'b0;
      o_pump_snk_force <= 1'b0;
      o_pump_test_on   <= 1'b0;
    end else if (i_ce) begin
      o_pump_test_on   <= (ptest == txm_pkg::PT_BOTH_ON)
                        | (ptest == txm_pkg::PT_SNK_ON)
                        | (ptest == txm_pkg::PT_SRC_ON)
                        | (ptest == txm_pkg::PT_OFF);
      o_pump_src_force <= (ptest == txm_pkg::PT_BOTH_ON)
                        | (ptest == txm_pkg::PT_SRC_ON);
      o_pump_snk_force <= (ptest == txm_pkg::PT_BOTH_ON)
                        | (ptest == txm_pkg::PT_SNK_ON);
    end
  end

  AST_PUMP_TEST: assert property (
    i_ce && ref_q[13:11] == 3'h6
      |=> o_pump_test_on && !o_pump_src_force && !o_pump_snk_force)
    else $error("pump test off code not honoured");

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_lock_indicator_pin <= 1'b0;
    end else if (i_ce) begin
      case (ref_q[txm_pkg::R_LOCK_LO +: 2])
        txm_pkg::LOCK_DET: begin
          o_lock_indicator_pin <= pin_s2_q[txm_pkg::P_LOCK];
        end
        txm_pkg::LOCK_MAIN: begin
          o_lock_indicator_pin <= pin_s2_q[txm_pkg::P_MDIV];
        end
        txm_pkg::LOCK_REF: begin
          o_lock_indicator_pin <= pin_s2_q[txm_pkg::P_RDIV];
        end
        default: begin
          o_lock_indicator_pin <= 1'b0;
        end
      endcase
    end
  end

  AST_LOCK_LOW: assert property (
    i_ce && ref_q[10:9] == 2'h3 |=> !o_lock_indicator_pin)
    else $error("lock pin not low for constant-low source");

  AST_LOCK_DET: assert property (
    i_ce && ref_q[10:9] == 2'h0
      |=> o_lock_indicator_pin == $past(pin_s2_q[3]))
    else $error("lock pin not following lock detect");

  COV_LOAD_MAIN: cover property (i_ce && load && addr == 4'h2);
  COV_STANDBY: cover property (
    mode_q == txm_pkg::TXM_ACTIVE ##1 mode_q == txm_pkg::TXM_STANDBY);
  COV_PIN_POWER_DOWN_CTL: cover property (
    i_ce && !pin_s2_q[txm_pkg::P_POWER_DOWN_CTL] && ctrl_q[0]);
  COV_BAD_ADDR: cover property (i_ce && load && addr == 4'h6);

endmodule : txm_ctrl_regs
`default_nettype wire

// ---- dv/txm_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module txm_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_serial_data_in
);
  initial begin
    o_sclk           = 1'b0;
    o_cs_n           = 1'b0;
    o_serial_data_in = 1'b0;
    // The bit counter has no reset; a chip-select rise arms it
    #1 o_cs_n = 1'b1;
  end

  // Serial clock only runs inside a frame, 48 ns period
  task automatic frame(input logic [20:0] w, input int n);
    #2.7;
    o_cs_n = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data_in = w[i];
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
    end
    #24 o_cs_n = 1'b1;
    // Released line shows the inverse so a held value cannot hide a bug
    o_serial_data_in = ~o_serial_data_in;
    #64;
  endtask : frame
endmodule : txm_host_model
`default_nettype wire

// ---- dv/test_txm_ctrl_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_txm_ctrl_regs;
  logic        clk_sys, resetn, ce, sclk, cs_n, serial_data_in, power_down_ctl_n, stby_n;
  logic        lock_det, mdiv, rdiv, cap_pll, cap_osc;
  logic        pll, osc, tx, fpow, bbf, dbl, max_power_sel, prd, outb, tmode;
  logic        src, snk, ptest, lockp;
  logic [1:0]  pump, trim;
  logic [8:0]  ratio;
  logic [15:0] mainv, ref_m, main_m, ctrl_m, d;
  logic [42:0] hold;
  logic [31:0] r;
  logic [3:0]  a;
  wire  [42:0] got;
  int          failures, num_checks, seed, n;

  assign got = {pll, osc, tx, fpow, bbf, dbl, max_power_sel, prd, outb, pump, trim,
                tmode, ratio, mainv, src, snk, ptest, lockp};

  txm_host_model u_txm_host_model (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_serial_data_in(serial_data_in));

  txm_ctrl_regs u_txm_ctrl_regs (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_ce(ce), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_serial_data_in(serial_data_in), .i_shutdown_n(power_down_ctl_n),
    .i_standby_n(stby_n), .i_lock_detect(lock_det),
    .i_main_div_out(mdiv), .i_ref_div_out(rdiv), .o_pll_on(pll),
    .o_oscillator_on(osc), .o_tx_chain_on(tx), .o_filter_power_on(fpow),
    .o_baseband_filter_on(bbf), .o_ref_doubler_on(dbl),
    .o_max_power_sel(max_power_sel), .o_predriver_bias_sel(prd),
    .o_output_bias_sel(outb), .o_pump_current_sel(pump),
    .o_trim_current_sel(trim), .o_offset_trim_mode(tmode),
    .o_ref_divide_ratio(ratio), .o_main_divider(mainv),
    .o_pump_src_force(src), .o_pump_snk_force(snk),
    .o_pump_test_on(ptest), .o_lock_indicator_pin(lockp));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [42:0] exp_out();
    logic       shut, sb, act, lk;
    logic [2:0] t;
    logic [1:0] l;
    shut = !power_down_ctl_n || !ctrl_m[0];
    sb   = !shut && !stby_n;
    act  = !shut && !sb;
    t    = ref_m[13:11];
    l    = ref_m[10:9];
    lk   = (l == 2'h0) ? lock_det : (l == 2'h1) ? mdiv :
           (l == 2'h2) ? rdiv : 1'b0;
    return {act ? ctrl_m[4] : sb & cap_pll,
            act ? ctrl_m[5] : sb & cap_osc,
            act & ctrl_m[6], act | (sb & ctrl_m[1]),
            ctrl_m[3], !shut & ctrl_m[7], ctrl_m[8], ctrl_m[9],
            ctrl_m[10], ctrl_m[12:11],
            ctrl_m[15] ? ctrl_m[14:13] : 2'h0, ctrl_m[15],
            ref_m[8:0], main_m, t == 3'h1 || t == 3'h5,
            t == 3'h1 || t == 3'h3,
            t == 3'h1 || t == 3'h3 || t == 3'h5 || t == 3'h6, lk};
  endfunction : exp_out

  task automatic check();
    repeat (6) @(posedge clk_sys);
    #1;
    num_checks++;
    if (got !== exp_out()) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h",
               $time, got, exp_out());
    end
  endtask : check

  // Standby entry captures the oscillator and PLL enables, as the device
  task automatic pins(input logic s, input logic b);
    @(posedge clk_sys);
    #1;
    if (!b && stby_n) begin
      cap_pll = ctrl_m[4];
      cap_osc = ctrl_m[5];
    end
    power_down_ctl_n   = s;
    stby_n   = b;
    r        = $random(seed);
    lock_det = r[0];
    mdiv     = r[1];
    rdiv     = r[2];
  endtask : pins

  task automatic wr(input logic [3:0] ad, input logic [15:0] dv, input int k);
    u_txm_host_model.frame({1'b0, dv, ad}, k);
    if (k == 20) begin
      case (ad)
        txm_pkg::ADDR_REF:  ref_m = dv;
        txm_pkg::ADDR_MAIN: main_m = dv;
        txm_pkg::ADDR_CTRL: ctrl_m = dv;
        default: ;
      endcase
    end
  endtask : wr

  task automatic stop_test();
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  initial begin
    #400000;
    failures++;
    stop_test();
  end

  initial begin
    seed = 10721;
    failures = 0;
    num_checks = 0;
    resetn = 1'b0;
    ce = 1'b1;
    power_down_ctl_n = 1'b1;
    stby_n = 1'b1;
    lock_det = 1'b0;
    mdiv = 1'b0;
    rdiv = 1'b0;
    cap_pll = 1'b0;
    cap_osc = 1'b0;
    ref_m = txm_pkg::RST_REF;
    main_m = txm_pkg::RST_MAIN;
    ctrl_m = txm_pkg::RST_CTRL;
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1'b1;
    check();
    for (int i = 0; i < 8; i++) begin
      wr(txm_pkg::ADDR_REF, {2'b01, i[2:0], i[1:0], 9'h0A5}, 20);
      check();
      wr(txm_pkg::ADDR_CTRL, {i[0], i[2:1], i[1:0], i[2:0], 8'h7D}, 20);
      check();
    end
    wr(txm_pkg::ADDR_MAIN, 16'hFFFF, 20);
    check();
    wr(4'h6, 16'h1234, 20);
    check();
    wr(txm_pkg::ADDR_MAIN, 16'h0001, 19);
    check();
    wr(txm_pkg::ADDR_MAIN, 16'h0002, 21);
    check();
    wr(txm_pkg::ADDR_CTRL, 16'h19FC, 20);
    check();
    wr(txm_pkg::ADDR_MAIN, 16'h1357, 20);
    check();
    pins(1'b0, 1'b1);
    wr(txm_pkg::ADDR_CTRL, 16'h197D, 20);
    check();
    pins(1'b1, 1'b1);
    wr(txm_pkg::ADDR_CTRL, 16'h1977, 20);
    check();
    wr(txm_pkg::ADDR_CTRL, 16'h197F, 20);
    pins(1'b1, 1'b0);
    check();
    wr(txm_pkg::ADDR_CTRL, 16'h194D, 20);
    check();
    pins(1'b1, 1'b1);
    check();
    // Clock enable low freezes every output while the shutdown pin moves
    @(posedge clk_sys);
    #1 ce = 1'b0;
    hold = got;
    pins(1'b0, 1'b1);
    repeat (6) @(posedge clk_sys);
    #1 num_checks++;
    if (got !== hold) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, hold);
    end
    ce = 1'b1;
    pins(1'b1, 1'b1);
    check();
    for (int k = 0; k < 80; k++) begin
      r = $random(seed);
      a = {1'b0, r[1:0], 1'b0};
      d = 16'($random(seed));
      if (a == txm_pkg::ADDR_CTRL)
        d[2] = 1'b1;
      if (a == txm_pkg::ADDR_REF)
        d[15:14] = 2'b01;
      n = (r[6:4] == 3'h0) ? 19 : (r[6:4] == 3'h1) ? 21 : 20;
      pins(r[9:7] != 3'h0, 1'b1);
      wr(a, d, n);
      check();
    end
    stop_test();
  end
endmodule : test_txm_ctrl_regs
`default_nettype wire
